// File: pkg/flag_bank_pkg.sv
package flag_bank_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	localparam int NUM_EXT = 3;

	////////////////////////////////////////////////////////////////////////////////
	localparam logic [11:0] OFS_EXT_FLAGS = 12'heca;
	localparam logic [11:0] OFS_CLK_ADC   = 12'hecb;
	localparam logic [11:0] OFS_ANALOG    = 12'hecc;
	localparam logic [11:0] OFS_SERIAL    = 12'hecd;
	localparam logic [11:0] OFS_TIMER     = 12'hece;
	localparam logic [11:0] OFS_GATE      = 12'hecf;
	localparam logic [11:0] OFS_CTRL      = 12'hff2;
	localparam logic [11:0] OFS_PIN_SEL0  = 12'he00;

	////////////////////////////////////////////////////////////////////////////////
	localparam int EXT_BIT0       = 0;
	localparam int PIN_CHANGE_BIT = 4;
	localparam int TMR0_BIT       = 5;
	localparam int OSC_FAIL_BIT   = 7;
	localparam int CSW_BIT        = 6;
	localparam int ADT_BIT        = 1;
	localparam int ADC_DONE_BIT   = 0;
	localparam int VD_BIT         = 7;
	localparam int ZC_BIT         = 6;
	localparam int CMP_BIT0       = 0;
	localparam int SSP1_BIT       = 0;
	localparam int BCL1_BIT       = 1;
	localparam int SSP2_BIT       = 2;
	localparam int BCL2_BIT       = 3;
	localparam int TX1_BIT        = 4;
	localparam int RX1_BIT        = 5;
	localparam int TX2_BIT        = 6;
	localparam int RX2_BIT        = 7;
	localparam int T1_OVF_BIT     = 0;
	localparam int T2_MATCH_BIT   = 1;
	localparam int T3_OVF_BIT     = 2;
	localparam int T4_MATCH_BIT   = 3;
	localparam int T5_OVF_BIT     = 4;
	localparam int T6_MATCH_BIT   = 5;
	localparam int GATE_BIT0      = 0;
	localparam int PERIPHERAL_IRQ_ENABLE_BIT       = 6;
	localparam int EDGE_BIT0      = 0;

	////////////////////////////////////////////////////////////////////////////////
	localparam logic [7:0] MASK_EXT_RW  = 8'h27;
	localparam logic [7:0] MASK_CLK_ADC = 8'hc3;
	localparam logic [7:0] MASK_ANALOG  = 8'hc3;
	localparam logic [7:0] MASK_SER_RW  = 8'h0f;
	localparam logic [7:0] MASK_TIMER   = 8'h3f;
	localparam logic [7:0] MASK_GATE    = 8'h07;
	localparam logic [7:0] FLAG_RESET   = 8'h00;
	localparam logic [2:0] EDGE_RESET   = 3'h7;
endpackage

// File: hw/sync2.sv
`timescale 1ns/1ns
module sync2 #(
	parameter int W = 1
) (
	input  wire logic         mclk,
	input  wire logic         rst_b,
	input  wire logic         ce,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} sync_state_t;

	sync_state_t st;
	sync_state_t next_st;

	if (W < 1) begin : g_bad_width
		$error("sync2: width must be at least 1");
	end

	// meta is read only by the second stage
	always_comb begin
		next_st = st;
		if (ce) begin
			next_st.meta   = d;
			next_st.stable = st.meta;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign q = st.stable;
endmodule // sync2

// File: hw/ext_edge_detect.sv
`timescale 1ns/1ns
module ext_edge_detect #(
	parameter int NUM_PINS = 8,
	parameter int SEL_W    = 3
) (
	input  wire logic                mclk,
	input  wire logic                rst_b,
	input  wire logic                ce,
	input  wire logic [NUM_PINS-1:0] pins,
	input  wire logic [SEL_W-1:0]    pin_sel,
	input  wire logic                rising,
	output logic                     evt
);
	typedef struct packed {
		logic prev;
		logic primed;
	} edge_state_t;

	edge_state_t st;
	edge_state_t next_st;
	logic        cur;

	if ((1 << SEL_W) < NUM_PINS) begin : g_bad_select
		$error("ext_edge_detect: select too narrow");
	end

	// pin chosen by software, not fixed
	assign cur = pins[pin_sel]; // [RQ4]

	// primed only masks the first enabled cycle after reset; a pin already high at reset still reads as a rising edge once through sync2
	assign evt = ce && st.primed && (rising ? (cur && !st.prev) : (!cur && st.prev)); // [RQ22]

	always_comb begin
		next_st = st;
		if (ce) begin
			next_st.prev   = cur;
			next_st.primed = 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	a_edge_polarity: assert property (@(posedge mclk) disable iff (!rst_b) // [RQ22]
		evt |-> (cur == rising) && ($past(cur) != rising || !$past(ce)))
		else $error("edge event against selected polarity");
endmodule // ext_edge_detect

// File: hw/peripheral_interrupt_flag_bank.sv
// Notes on behaviour
// RQ1 - each of three external inputs sets its own flag on its event
// RQ2 - first flag register pending is never masked by peripheral enable
// RQ3 - pin-change flag read-only, clears only when all per-pin flags clear
// RQ4 - each external input pin chosen by a pin-select register
// RQ5 - oscillator failure sets clock/adc bit 7, software clears
// RQ6 - new oscillator ready sets clock/adc bit 6
// RQ7 - clock-switch-ready flag alone never wakes from sleep
// RQ8 - adc threshold event sets clock/adc bit 1
// RQ9 - conversion done sets clock/adc bit 0 until software clears
// RQ10 - voltage detect event sets analog bit 7
// RQ11 - any zero-cross output change sets analog bit 6
// RQ12 - comparator output change sets analog bit 0 or 1
// RQ13 - serial bits 5 and 7 mirror receive buffer full, read-only
// RQ14 - serial bits 4 and 6 mirror transmit buffer empty, read-only
// RQ15 - bus collision sets serial bits 1 and 3
// RQ16 - sync port transfer done sets serial bits 0 and 2
// RQ17 - 8-bit timer period match sets timer bits 1, 3, 5
// RQ18 - 16-bit timer overflow sets timer bits 0, 2, 4
// RQ19 - timer gate events set gate bits 0, 1, 2
// RQ20 - hardware-set flags stay set until software writes zero
// RQ21 - flags set regardless of any enable, allowing polling
// RQ22 - external input edge select: 1 rising, 0 falling
// RQ23 - flags reset to zero; unused bits read zero, ignore writes
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ns
module peripheral_interrupt_flag_bank
	import flag_bank_pkg::*;
#(
	parameter int NUM_PINS = 8
) (
	input  wire logic                mclk,
	input  wire logic                rst_b,
	input  wire logic                ce,
	input  wire logic [ADDR_W-1:0]   addr,
	input  wire logic [DATA_W-1:0]   wdata,
	input  wire logic                wr_en,
	input  wire logic                rd_en,
	output logic      [DATA_W-1:0]   rdata,
	input  wire logic [NUM_PINS-1:0] gpio_pins,
	input  wire logic [NUM_PINS-1:0] per_pin_change_flags,
	input  wire logic                timer_zero_ovf,
	input  wire logic                osc_fail_evt,
	input  wire logic                clk_switch_ready_evt,
	input  wire logic                adc_threshold_evt,
	input  wire logic                adc_done_evt,
	input  wire logic                voltage_detect_evt,
	input  wire logic                zero_cross_out,
	input  wire logic [1:0]          comparator_out,
	input  wire logic [1:0]          uart_rx_full,
	input  wire logic [1:0]          uart_tx_empty,
	input  wire logic [1:0]          bus_collision_evt,
	input  wire logic [1:0]          sync_serial_done_evt,
	input  wire logic [2:0]          timer_match_evt,
	input  wire logic [2:0]          timer_overflow_evt,
	input  wire logic [2:0]          timer_gate_evt,
	output logic                     core_event_pending,
	output logic                     periph_event_pending,
	output logic                     wake_request
);
	localparam int SEL_W = (NUM_PINS > 1) ? $clog2(NUM_PINS) : 1;

	typedef struct packed {
		logic [7:0]                        ext_flags;
		logic [7:0]                        clk_adc;
		logic [7:0]                        analog;
		logic [7:0]                        serial_rw;
		logic [7:0]                        timer;
		logic [7:0]                        gate;
		logic                              peripheral_irq_enable;
		logic [NUM_EXT-1:0]                edge_sel;
		logic [NUM_EXT-1:0][SEL_W-1:0]     pin_sel;
		logic [2:0]                        analog_prev;
		logic                              primed;
		logic [7:0]                        rdata;
	} bank_state_t;

	bank_state_t          st;
	bank_state_t          next_st;
	logic [NUM_PINS-1:0]  pins_sync;
	logic [NUM_EXT-1:0]   ext_evt;
	logic                 pin_change;
	logic [2:0]           analog_now;
	logic [7:0]           ser_view;
	logic                 other_pending;

	// stop at elaboration on a pin count the select fields cannot serve
	if (NUM_PINS < 2 || NUM_PINS > 256) begin : g_bad_pins
		$error("flag bank: NUM_PINS out of range");
	end

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
		return a == ofs;
	endfunction

	// write stores masked data, then hardware set wins over a same-cycle clear
	function automatic logic [7:0] upd(input logic [7:0] cur, input logic [7:0] set,
		input logic we, input logic [7:0] d, input logic [7:0] mask);
		logic [7:0] base;
		base = we ? d : cur;
		return (base | set) & mask;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	sync2 #(
		.W (NUM_PINS)
	) u_pin_sync (
		.mclk  (mclk),
		.rst_b (rst_b),
		.ce    (ce),
		.d     (gpio_pins),
		.q     (pins_sync)
	);

	for (genvar i = 0; i < NUM_EXT; i++) begin : g_ext
		ext_edge_detect #(
			.NUM_PINS (NUM_PINS),
			.SEL_W    (SEL_W)
		) u_edge (
			.mclk    (mclk),
			.rst_b   (rst_b),
			.ce      (ce),
			.pins    (pins_sync),
			.pin_sel (st.pin_sel[i]),
			.rising  (st.edge_sel[i]),
			.evt     (ext_evt[i])
		);
	end

	////////////////////////////////////////////////////////////////////////////////
	// pin-change is live: per-pin flags are the only storage
	assign pin_change = |per_pin_change_flags; // [RQ3]
	assign analog_now = {zero_cross_out, comparator_out};

	// serial view: buffer bits follow the uart state, never stored here
	always_comb begin
		ser_view          = st.serial_rw & MASK_SER_RW;
		ser_view[RX1_BIT] = uart_rx_full[0]; // [RQ13]
		ser_view[RX2_BIT] = uart_rx_full[1]; // [RQ13]
		ser_view[TX1_BIT] = uart_tx_empty[0]; // [RQ14]
		ser_view[TX2_BIT] = uart_tx_empty[1]; // [RQ14]
	end

	always_comb begin
		logic [7:0] s_ext;
		logic [7:0] s_clk;
		logic [7:0] s_ana;
		logic [7:0] s_ser;
		logic [7:0] s_tmr;
		logic [7:0] s_gate;
		logic [2:0] changed;
		logic [7:0] ext_view;
		s_ext   = '0;
		s_clk   = '0;
		s_ana   = '0;
		s_ser   = '0;
		s_tmr   = '0;
		s_gate  = '0;
		ext_view = '0;
		changed = st.primed ? (analog_now ^ st.analog_prev) : 3'h0;
		next_st = st;

		// sources are not qualified by any enable so software can poll
		s_ext[EXT_BIT0 +: NUM_EXT]  = ext_evt; // [RQ1] [RQ21]
		s_ext[TMR0_BIT]             = timer_zero_ovf;
		s_clk[OSC_FAIL_BIT]         = osc_fail_evt; // [RQ5]
		s_clk[CSW_BIT]              = clk_switch_ready_evt; // [RQ6]
		s_clk[ADT_BIT]              = adc_threshold_evt; // [RQ8]
		s_clk[ADC_DONE_BIT]         = adc_done_evt; // [RQ9]
		s_ana[VD_BIT]               = voltage_detect_evt; // [RQ10]
		s_ana[ZC_BIT]               = changed[2]; // [RQ11]
		s_ana[CMP_BIT0 +: 2]        = changed[1:0]; // [RQ12]
		s_ser[SSP1_BIT]             = sync_serial_done_evt[0]; // [RQ16]
		s_ser[SSP2_BIT]             = sync_serial_done_evt[1]; // [RQ16]
		s_ser[BCL1_BIT]             = bus_collision_evt[0]; // [RQ15]
		s_ser[BCL2_BIT]             = bus_collision_evt[1]; // [RQ15]
		s_tmr[T2_MATCH_BIT]         = timer_match_evt[0]; // [RQ17]
		s_tmr[T4_MATCH_BIT]         = timer_match_evt[1]; // [RQ17]
		s_tmr[T6_MATCH_BIT]         = timer_match_evt[2]; // [RQ17]
		s_tmr[T1_OVF_BIT]           = timer_overflow_evt[0]; // [RQ18]
		s_tmr[T3_OVF_BIT]           = timer_overflow_evt[1]; // [RQ18]
		s_tmr[T5_OVF_BIT]           = timer_overflow_evt[2]; // [RQ18]
		s_gate[GATE_BIT0 +: 3]      = timer_gate_evt; // [RQ19]

		ext_view                 = st.ext_flags & MASK_EXT_RW;
		ext_view[PIN_CHANGE_BIT] = pin_change; // [RQ3]

		if (ce) begin
			// flags only drop on a software write of zero
			next_st.ext_flags = upd(st.ext_flags, s_ext, wr_en && hit(addr, OFS_EXT_FLAGS),
				wdata, MASK_EXT_RW); // [RQ20] [RQ23]
			next_st.clk_adc   = upd(st.clk_adc, s_clk, wr_en && hit(addr, OFS_CLK_ADC),
				wdata, MASK_CLK_ADC); // [RQ20] [RQ23]
			next_st.analog    = upd(st.analog, s_ana, wr_en && hit(addr, OFS_ANALOG),
				wdata, MASK_ANALOG); // [RQ20] [RQ23]
			next_st.serial_rw = upd(st.serial_rw, s_ser, wr_en && hit(addr, OFS_SERIAL),
				wdata, MASK_SER_RW); // [RQ20] [RQ23]
			next_st.timer     = upd(st.timer, s_tmr, wr_en && hit(addr, OFS_TIMER),
				wdata, MASK_TIMER); // [RQ20] [RQ23]
			next_st.gate      = upd(st.gate, s_gate, wr_en && hit(addr, OFS_GATE),
				wdata, MASK_GATE); // [RQ20] [RQ23]
			next_st.analog_prev = analog_now;
			next_st.primed      = 1'b1;

			if (wr_en && hit(addr, OFS_CTRL)) begin
				next_st.peripheral_irq_enable     = wdata[PERIPHERAL_IRQ_ENABLE_BIT];
				next_st.edge_sel = wdata[EDGE_BIT0 +: NUM_EXT]; // [RQ22]
			end
			for (int i = 0; i < NUM_EXT; i++) begin
				if (wr_en && hit(addr, OFS_PIN_SEL0 + ADDR_W'(i))) begin
					next_st.pin_sel[i] = wdata[SEL_W-1:0]; // [RQ4]
				end
			end

			// read data stands one cycle only, zero otherwise
			next_st.rdata = '0;
			if (rd_en) begin
				if (hit(addr, OFS_EXT_FLAGS)) next_st.rdata = ext_view;
				if (hit(addr, OFS_CLK_ADC)) next_st.rdata = st.clk_adc;
				if (hit(addr, OFS_ANALOG)) next_st.rdata = st.analog;
				if (hit(addr, OFS_SERIAL)) next_st.rdata = ser_view;
				if (hit(addr, OFS_TIMER)) next_st.rdata = st.timer;
				if (hit(addr, OFS_GATE)) next_st.rdata = st.gate;
				if (hit(addr, OFS_CTRL)) begin
					next_st.rdata[PERIPHERAL_IRQ_ENABLE_BIT]              = st.peripheral_irq_enable;
					next_st.rdata[EDGE_BIT0 +: NUM_EXT]  = st.edge_sel;
				end
				for (int i = 0; i < NUM_EXT; i++) begin
					if (hit(addr, OFS_PIN_SEL0 + ADDR_W'(i))) begin
						next_st.rdata[SEL_W-1:0] = st.pin_sel[i];
					end
				end
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			st           <= '0;
			st.edge_sel  <= EDGE_RESET;
			st.ext_flags <= FLAG_RESET; // [RQ23]
			st.clk_adc   <= FLAG_RESET;
			st.analog    <= FLAG_RESET;
			st.serial_rw <= FLAG_RESET;
			st.timer     <= FLAG_RESET;
			st.gate      <= FLAG_RESET;
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	assign rdata = st.rdata;

	// first register bypasses the peripheral enable
	assign core_event_pending = ((st.ext_flags & MASK_EXT_RW) != 8'h00) || pin_change; // [RQ2]

	assign other_pending = ((st.clk_adc & ~(8'h01 << CSW_BIT)) != 8'h00) ||
		(st.analog != 8'h00) || (ser_view != 8'h00) || (st.timer != 8'h00) ||
		(st.gate != 8'h00);

	assign periph_event_pending = st.peripheral_irq_enable && (other_pending || st.clk_adc[CSW_BIT]);

	// clock-switch ready is kept out: it must not end sleep on its own
	assign wake_request = core_event_pending || other_pending; // [RQ7]

	////////////////////////////////////////////////////////////////////////////////
	a_ext_flag_set: assert property (@(posedge mclk) disable iff (!rst_b) // [RQ1]
		(ce && ext_evt != '0) |=> ((st.ext_flags[EXT_BIT0 +: NUM_EXT] & $past(ext_evt))
		== $past(ext_evt)))
		else $error("external event did not set its flag");

	a_core_unmasked: assert property (@(posedge mclk) disable iff (!rst_b) // [RQ2]
		(!st.peripheral_irq_enable && st.ext_flags[EXT_BIT0]) |-> core_event_pending && !periph_event_pending)
		else $error("first register pending masked");

	a_pin_change_read: assert property (@(posedge mclk) disable iff (!rst_b) // [RQ3]
		(ce && rd_en && hit(addr, OFS_EXT_FLAGS)) |=>
		(rdata[PIN_CHANGE_BIT] == $past(|per_pin_change_flags)))
		else $error("pin change bit not live");

	a_osc_fail_set: assert property (@(posedge mclk) disable iff (!rst_b) // [RQ5]
		(ce && osc_fail_evt) |=> st.clk_adc[OSC_FAIL_BIT] ##1
		(st.clk_adc[OSC_FAIL_BIT] || $past(ce && wr_en && addr == OFS_CLK_ADC)))
		else $error("oscillator fail flag lost");

	a_switch_no_wake: assert property (@(posedge mclk) disable iff (!rst_b) // [RQ7]
		(st.clk_adc == (8'h01 << CSW_BIT) && st.analog == 8'h00 && ser_view == 8'h00 &&
		st.timer == 8'h00 && st.gate == 8'h00 && !core_event_pending) |-> !wake_request)
		else $error("clock switch flag woke the system");

	a_adc_done_hold: assert property (@(posedge mclk) disable iff (!rst_b) // [RQ9]
		(st.clk_adc[ADC_DONE_BIT] && !(wr_en && hit(addr, OFS_CLK_ADC)))
		|=> st.clk_adc[ADC_DONE_BIT])
		else $error("conversion flag dropped without a write");

	a_zero_cross_set: assert property (@(posedge mclk) disable iff (!rst_b) // [RQ11]
		(ce && $past(ce) && st.primed && $changed(zero_cross_out)) |-> ##1 st.analog[ZC_BIT])
		else $error("zero cross change missed");

	a_cmp_change: assert property (@(posedge mclk) disable iff (!rst_b) // [RQ12]
		(ce && st.primed && comparator_out[0] != st.analog_prev[0]) |=> st.analog[CMP_BIT0])
		else $error("comparator change missed");

	a_rx_mirror: assert property (@(posedge mclk) disable iff (!rst_b) // [RQ13]
		(ce && rd_en && hit(addr, OFS_SERIAL)) |=>
		(rdata[RX1_BIT] == $past(uart_rx_full[0]) && rdata[TX2_BIT] == $past(uart_tx_empty[1])))
		else $error("serial buffer bits not mirrored");

	a_set_beats_clear: assert property (@(posedge mclk) disable iff (!rst_b) // [RQ20]
		(ce && wr_en && hit(addr, OFS_CLK_ADC) && wdata == 8'h00 && adc_done_evt)
		|=> st.clk_adc[ADC_DONE_BIT])
		else $error("same-cycle clear beat the conversion flag");

	a_gate_set: assert property (@(posedge mclk) disable iff (!rst_b) // [RQ19]
		(ce && timer_gate_evt[2]) |=> st.gate[GATE_BIT0 + 2])
		else $error("gate flag not set");

	a_reserved_zero: assert property (@(posedge mclk) disable iff (!rst_b) // [RQ23]
		(ce && rd_en && hit(addr, OFS_TIMER)) |=> rdata[7:6] == 2'b00 ##1
		(rdata == 8'h00 || $past(rd_en || !ce)))
		else $error("reserved bits or stale read data");

	a_switch_ready_set: assert property (@(posedge mclk) disable iff (!rst_b) // [RQ6]
		(ce && clk_switch_ready_evt) |=> st.clk_adc[CSW_BIT])
		else $error("clock switch ready flag not set");

	a_threshold_set: assert property (@(posedge mclk) disable iff (!rst_b) // [RQ8]
		(ce && adc_threshold_evt) |=> st.clk_adc[ADT_BIT])
		else $error("threshold flag not set");

	a_voltage_set: assert property (@(posedge mclk) disable iff (!rst_b) // [RQ10]
		(ce && voltage_detect_evt) |=> st.analog[VD_BIT])
		else $error("voltage detect flag not set");

	a_collision_set: assert property (@(posedge mclk) disable iff (!rst_b) // [RQ15]
		(ce && bus_collision_evt[1]) |=> st.serial_rw[BCL2_BIT])
		else $error("collision flag not set");

	a_sync_done_set: assert property (@(posedge mclk) disable iff (!rst_b) // [RQ16]
		(ce && sync_serial_done_evt[0]) |=> st.serial_rw[SSP1_BIT])
		else $error("sync transfer flag not set");

	a_match_set: assert property (@(posedge mclk) disable iff (!rst_b) // [RQ17]
		(ce && timer_match_evt[2]) |=> st.timer[T6_MATCH_BIT])
		else $error("period match flag not set");

	a_overflow_set: assert property (@(posedge mclk) disable iff (!rst_b) // [RQ18]
		(ce && timer_overflow_evt[1]) |=> st.timer[T3_OVF_BIT])
		else $error("overflow flag not set");

	a_tx_mirror: assert property (@(posedge mclk) disable iff (!rst_b) // [RQ14]
		(ce && rd_en && hit(addr, OFS_SERIAL)) |=>
		(rdata[TX1_BIT] == $past(uart_tx_empty[0]) && rdata[RX2_BIT] == $past(uart_rx_full[1])))
		else $error("transmit buffer bit not mirrored");
endmodule // peripheral_interrupt_flag_bank

// File: verif/event_source_model.sv
`timescale 1ns/1ns
module event_source_model (
	input  wire logic        mclk,
	input  wire logic        rst_b,
	input  wire logic [18:0] pulse_req,
	input  wire logic [6:0]  level_req,
	output logic      [18:0] pulse,
	output logic      [6:0]  level
);
	////////////////////////////////////////////////////////////
	// registered so that every event lands just after an edge
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pulse <= '0;
			level <= '0;
		end else begin
			pulse <= pulse_req; // sources fire whatever the enables
			level <= level_req; // held levels
		end
	end
endmodule // event_source_model

// File: verif/tb_peripheral_interrupt_flag_bank.sv
`timescale 1ns/1ns
module tb_peripheral_interrupt_flag_bank
	import flag_bank_pkg::*;
();
	logic              mclk, rst_b, ce, wr_en, rd_en;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata, rdata;
	logic [7:0]        gpio_pins, pin_chg, exp_reg [6];
	logic [18:0]       pulse_req, pulse;
	logic [6:0]        level_req, level;
	logic              core_event_pending, periph_event_pending, wake_request;
	int                failures, checks, base;
	localparam logic [11:0] P_ADDR [19] = '{OFS_EXT_FLAGS, OFS_CLK_ADC, OFS_CLK_ADC,
		OFS_CLK_ADC, OFS_CLK_ADC, OFS_ANALOG, OFS_SERIAL, OFS_SERIAL, OFS_SERIAL,
		OFS_SERIAL, OFS_TIMER, OFS_TIMER, OFS_TIMER, OFS_TIMER, OFS_TIMER, OFS_TIMER,
		OFS_GATE, OFS_GATE, OFS_GATE};
	localparam int P_BIT [19] = '{TMR0_BIT, OSC_FAIL_BIT, CSW_BIT, ADT_BIT, ADC_DONE_BIT,
		VD_BIT, BCL1_BIT, BCL2_BIT, SSP1_BIT, SSP2_BIT, T2_MATCH_BIT, T4_MATCH_BIT,
		T6_MATCH_BIT, T1_OVF_BIT, T3_OVF_BIT, T5_OVF_BIT, GATE_BIT0, GATE_BIT0 + 1,
		GATE_BIT0 + 2};

	always #10 mclk = ~mclk;

	event_source_model u_src (.mclk(mclk), .rst_b(rst_b), .pulse_req(pulse_req),
		.level_req(level_req), .pulse(pulse), .level(level));

	peripheral_interrupt_flag_bank u_dut (.mclk(mclk), .rst_b(rst_b), .ce(ce), .addr(addr),
		.wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .gpio_pins(gpio_pins),
		.per_pin_change_flags(pin_chg), .timer_zero_ovf(pulse[0]), .osc_fail_evt(pulse[1]),
		.clk_switch_ready_evt(pulse[2]), .adc_threshold_evt(pulse[3]),
		.adc_done_evt(pulse[4]), .voltage_detect_evt(pulse[5]), .zero_cross_out(level[0]),
		.comparator_out(level[2:1]), .uart_rx_full(level[4:3]), .uart_tx_empty(level[6:5]),
		.bus_collision_evt(pulse[7:6]), .sync_serial_done_evt(pulse[9:8]),
		.timer_match_evt(pulse[12:10]), .timer_overflow_evt(pulse[15:13]),
		.timer_gate_evt(pulse[18:16]), .core_event_pending(core_event_pending),
		.periph_event_pending(periph_event_pending), .wake_request(wake_request));

	////////////////////////////////////////////////////////////
	// expectation helpers; live bits come from the bench's own drives
	function automatic logic [7:0] exp_of(int r);
		logic [7:0] v;
		v = exp_reg[r];
		if (r == 0) v[PIN_CHANGE_BIT] = |pin_chg;
		if (r == 3) v[7:4] = {level_req[4], level_req[6], level_req[3], level_req[5]};
		return v;
	endfunction

	function automatic void add_pulses(logic [18:0] p);
		for (int i = 0; i < 19; i++)
			if (p[i]) exp_reg[P_ADDR[i] - OFS_EXT_FLAGS][P_BIT[i]] = 1'b1;
	endfunction

	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge mclk);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge mclk);
		wr_en <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, output logic [7:0] d);
		@(posedge mclk);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge mclk);
		rd_en <= 1'b0;
		#1 d = rdata;
	endtask

	task automatic chk_reg(input logic [11:0] a, input logic [7:0] e);
		logic [7:0] v;
		rd(a, v);
		chk_byte(v, e);
	endtask

	task automatic check_all();
		for (int r = 0; r < 6; r++)
			chk_reg(OFS_EXT_FLAGS + 12'(r), exp_of(r));
	endtask

	task automatic clear_all();
		for (int r = 0; r < 6; r++) begin
			wr(OFS_EXT_FLAGS + 12'(r), 8'h00);
			exp_reg[r] = 8'h00;
		end
	endtask

	// a pulse only for the cycle after the request, so each is one event
	task automatic fire(input logic [18:0] p);
		@(posedge mclk);
		pulse_req <= p;
		@(posedge mclk);
		pulse_req <= '0;
		@(posedge mclk);
		add_pulses(p);
		#1;
	endtask

	task automatic set_levels(input logic [6:0] v);
		@(posedge mclk);
		exp_reg[2][ZC_BIT] |= v[0] ^ level_req[0];
		exp_reg[2][1:0] |= v[2:1] ^ level_req[2:1];
		level_req <= v;
		repeat (4) @(posedge mclk);
	endtask

	task automatic final_report();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge mclk);
		failures++;
		final_report();
	end

	initial begin
		mclk = 1'b0;
		rst_b = 1'b0;
		ce = 1'b1;
		{wr_en, rd_en, addr, wdata, gpio_pins, pin_chg, pulse_req, level_req} = '0;
		failures = 0;
		checks = 0;
		foreach (exp_reg[r]) exp_reg[r] = 8'h00;
		void'($urandom(92116));
		repeat (6) @(posedge mclk);
		rst_b <= 1'b1;
		check_all();
		chk_reg(OFS_CTRL, 8'h07);
		for (int r = 0; r < 6; r++) wr(OFS_EXT_FLAGS + 12'(r), 8'hff);
		exp_reg = '{MASK_EXT_RW, MASK_CLK_ADC, MASK_ANALOG, MASK_SER_RW, MASK_TIMER, MASK_GATE};
		check_all();
		chk_bit(wake_request, 1'b1);
		clear_all();
		check_all();
		wr(12'h123, 8'hff);
		chk_reg(12'h123, 8'h00);
		// one source at a time with every enable off
		for (int i = 0; i < 19; i++) begin
			fire(19'(1) << i);
			chk_bit(wake_request, i != 2);
			chk_bit(core_event_pending, i == 0);
			chk_bit(periph_event_pending, 1'b0);
			check_all();
			clear_all();
		end
		wr(OFS_CTRL, 8'h47);
		fire(19'h00004);
		chk_bit(periph_event_pending, 1'b1);
		chk_bit(wake_request, 1'b0);
		clear_all();
		fire(19'h00001);
		chk_bit(core_event_pending, 1'b1);
		chk_bit(periph_event_pending, 1'b0);
		clear_all();
		wr(OFS_CTRL, 8'h07);
		// set and software clear in the same cycle: set must win
		@(posedge mclk);
		pulse_req <= 19'h00010;
		@(posedge mclk);
		pulse_req <= '0;
		wr_en <= 1'b1;
		addr <= OFS_CLK_ADC;
		wdata <= 8'h00;
		@(posedge mclk);
		wr_en <= 1'b0;
		exp_reg[1] = 8'h01;
		check_all();
		clear_all();
		// pin change bit follows the per-pin flags only
		@(posedge mclk);
		pin_chg <= 8'h24;
		wr(OFS_EXT_FLAGS, 8'h00);
		#1;
		chk_bit(core_event_pending, 1'b1);
		chk_reg(OFS_EXT_FLAGS, 8'h10);
		@(posedge mclk);
		pin_chg <= 8'h04;
		chk_reg(OFS_EXT_FLAGS, 8'h10);
		@(posedge mclk);
		pin_chg <= 8'h00;
		chk_reg(OFS_EXT_FLAGS, 8'h00);
		// external inputs on chosen pins, both edge senses
		for (int e = 1; e >= 0; e--) begin
			base = $urandom_range(7);
			wr(OFS_CTRL, {5'h00, {3{e[0]}}});
			for (int i = 0; i < NUM_EXT; i++) begin
				wr(OFS_PIN_SEL0 + 12'(i), 8'((base + i) % 8));
				chk_reg(OFS_PIN_SEL0 + 12'(i), 8'((base + i) % 8));
			end
			@(posedge mclk);
			gpio_pins <= e[0] ? 8'h00 : 8'hff;
			repeat (8) @(posedge mclk);
			clear_all();
			for (int i = 0; i < NUM_EXT; i++) begin
				@(posedge mclk);
				gpio_pins[(base + i) % 8] <= e[0];
				repeat (6) @(posedge mclk);
				exp_reg[0][i] = 1'b1;
				check_all();
			end
			@(posedge mclk);
			gpio_pins <= ~gpio_pins;
			repeat (6) @(posedge mclk);
			check_all();
			clear_all();
		end
		// random mixes; flags must hold across idle gaps
		repeat (24) begin
			fire(19'($urandom));
			set_levels(7'($urandom));
			if ($urandom_range(1) == 1) fire(19'($urandom));
			repeat ($urandom_range(5)) @(posedge mclk);
			check_all();
			clear_all();
			check_all();
		end
		// reset in mid-run with every pulse-sourced flag set; quiet pins so no edge follows
		fire(19'h7ffff);
		@(posedge mclk);
		rst_b <= 1'b0;
		{gpio_pins, level_req} <= '0;
		repeat (2) @(posedge mclk);
		rst_b <= 1'b1;
		foreach (exp_reg[r]) exp_reg[r] = 8'h00;
		check_all();
		chk_bit(wake_request, 1'b0);
		chk_reg(OFS_CTRL, 8'h07);
		final_report();
	end
endmodule // tb_peripheral_interrupt_flag_bank
